/* logic/key_debounce.v */
`timescale 1ns/1ps
`default_nettype none
`include "keypad_map.vh"
module key_debounce #(
	parameter CNT_MAX = `DEBOUNCE_MS * `CLK_KHZ
) (
	input  wire core_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire key_pin,
	output reg  key_level
);
	reg        sync1_reg;
	reg        sync2_reg;
	reg [17:0] cnt_reg;
	// two stages before anything reads the pin
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			cnt_reg   <= 18'h00000;
			key_level <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= key_pin;
			sync2_reg <= sync1_reg;
			if (sync2_reg == key_level)
				cnt_reg <= 18'h00000;
			else if (cnt_reg == CNT_MAX[17:0] - 18'h00001) begin
				cnt_reg   <= 18'h00000;
				key_level <= sync2_reg;
			end else
				cnt_reg <= cnt_reg + 18'h00001;
		end
	end
endmodule // key_debounce
`default_nettype wire

/* logic/keypad_key_led_controller.v */
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_map.vh"
// Operation
// - mode key toggles display mode (steady cursor) and programming mode (blinking).
// - step-down key lowers page in display mode, value in programming mode.
// - step-up key raises page in display mode, value in programming mode.
// - save key, programming mode only, stores page value into non-volatile store.
// - jog key, keypad selected, enables jog while held.
// - direction key, keypad selected, reverses speed reference polarity.
// - start key, keypad selected, sets latched run command.
// - stop key stops when keypad selected, or always with override setting 0.
// - stepped values take effect at once; unsaved values lost at power-off.
// - mode+save chord asserts alarm reset input.
// - down+up chord cycles access, measure, status pages, then returns.
// - up+save chord enters local mode if permit is 0 and drive idle.
// - local mode never stored; power-up uses saved source selection.
// - one page is 32 characters, two lines of sixteen.
// - run LED on while firing, blinks during stop ramp, board LED mirrors.
// - speed reference configured: reference LED lights on nonzero speed reference.
// - only current references: reference LED lights on nonzero current reference.
// - direction LEDs show rotation running; flash by prepared polarity when idle.
// - idle polarity indications ignore additional references.
// - local command LED on only keypad, flashes mixed, off unselected.
// - local reference LED on only stepped source, flashes mixed, off unselected.
// - braking LED on while braking; current-limit LED and board mirror in limit.
// - local mode restricts sources to stepped reference and keypad.
module keypad_key_led_controller #(
	parameter DEBOUNCE_CYCLES = `DEBOUNCE_MS * `CLK_KHZ,
	parameter BLINK_CYCLES    = `BLINK_MS * `CLK_KHZ
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire [7:0]  key_pins,
	input  wire        drive_firing,
	input  wire        stop_ramp_active,
	input  wire        speed_ref_cfg,
	input  wire        current_ref_cfg,
	input  wire        speed_ref_nonzero,
	input  wire        current_ref_nonzero,
	input  wire        motor_reverse,
	input  wire        prepared_ref_negative,
	input  wire        braking_active,
	input  wire        current_limit,
	input  wire        awaddr_valid_dummy,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         mode_toggle_key_mode,
	output reg  [7:0]  page_num,
	output reg  [15:0] page_value,
	output reg         value_save_pulse,
	output reg         jog_cmd,
	output reg         ref_reverse,
	output reg         run_cmd,
	output reg         alarm_reset,
	output reg         local_mode,
	output reg  [3:0]  cmd_src_active,
	output reg  [3:0]  ref_src_active,
	output reg         run_led,
	output reg         board_run_led,
	output reg         ref_led,
	output reg         fwd_led,
	output reg         rev_led,
	output reg         local_command_led,
	output reg         local_reference_led,
	output reg         brake_led,
	output reg         current_limit_led,
	output reg         board_current_limit_led
);
	localparam [5:0] PAGE_CHARS = `DISPLAY_CHARS;
	wire [7:0] key_lvl;
	wire [15:0] store_rd;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_deb
			key_debounce #(.CNT_MAX(DEBOUNCE_CYCLES)) u_deb (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.clk_en   (clk_en),
				.key_pin  (key_pins[gi]),
				.key_level(key_lvl[gi])
			);
		end
	endgenerate

	reg [7:0]  key_prev_reg;
	reg        ctrl_lsp_reg;
	reg        ctrl_sko_reg;
	reg [3:0]  saved_cmd_reg;
	reg [3:0]  saved_ref_reg;
	reg [1:0]  mon_reg;
	reg [7:0]  mon_ret_reg;
	reg [7:0]  save_addr_reg;
	reg [23:0] blink_cnt_reg;
	reg        blink_reg;
	reg        load_reg;
	reg        load_dly_reg;
	reg        chord_hold_reg;

	wire ch_alarm = key_lvl[`K_MODE] & key_lvl[`K_SAVE];
	wire ch_mon   = key_lvl[`K_DOWN] & key_lvl[`K_UP];
	wire ch_local = key_lvl[`K_UP] & key_lvl[`K_SAVE];
	wire any_chord = ch_alarm | ch_mon | ch_local;
	wire [7:0] rise = key_lvl & ~key_prev_reg;
	// single keys suppressed while a chord is or was held
	wire single_ok = ~any_chord & ~chord_hold_reg;
	wire [3:0] cmd_src = local_mode ? (4'h1 << `SRC_KEYPAD_BIT) : saved_cmd_reg;
	wire [3:0] ref_src = local_mode ? (4'h1 << `SRC_STEPPED_BIT) : saved_ref_reg;
	wire keypad_sel  = cmd_src[`SRC_KEYPAD_BIT];
	wire stepped_sel = ref_src[`SRC_STEPPED_BIT];

	// bus signals
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
	wire sw_value_wr = wr_go && s_axi_awaddr == `REG_VALUE && s_axi_wstrb[0];

	page_store u_store (
		.core_clk(core_clk),
		.clk_en  (clk_en),
		.wr_en   (value_save_pulse),
		.wr_addr (save_addr_reg),
		.wr_data (page_value),
		.rd_addr (page_num),
		.rd_data (store_rd)
	);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_prev_reg     <= 8'h00;
			chord_hold_reg   <= 1'b0;
			mode_toggle_key_mode        <= 1'b0;
			page_num         <= `PAGE_ACCESS;
			page_value       <= 16'h0000;
			value_save_pulse <= 1'b0;
			save_addr_reg    <= 8'h00;
			jog_cmd          <= 1'b0;
			ref_reverse      <= 1'b0;
			run_cmd          <= 1'b0;
			alarm_reset      <= 1'b0;
			local_mode       <= 1'b0;
			mon_reg          <= `MON_OFF;
			mon_ret_reg      <= 8'h00;
			load_reg         <= 1'b0;
			load_dly_reg     <= 1'b0;
		end else if (clk_en) begin
			key_prev_reg     <= key_lvl;
			value_save_pulse <= 1'b0;
			load_reg         <= 1'b0;
			load_dly_reg     <= load_reg;
			if (any_chord)
				chord_hold_reg <= 1'b1;
			else if (key_lvl == 8'h00)
				chord_hold_reg <= 1'b0;
			// reset input held while chord held
			alarm_reset <= ch_alarm;
			// jog follows key while keypad selected
			jog_cmd <= key_lvl[`K_JOG] & keypad_sel & single_ok;
			// store read data lag the new page by one cycle
			if (load_dly_reg && !mode_toggle_key_mode)
				page_value <= store_rd;
			if (sw_value_wr)
				page_value <= s_axi_wdata[15:0];
			if (rise[`K_MODE] && single_ok)
				mode_toggle_key_mode <= ~mode_toggle_key_mode;
			if (rise[`K_DOWN] && single_ok) begin
				if (mode_toggle_key_mode)
					page_value <= page_value - 16'h0001;
				else begin
					page_num <= page_num - 8'h01;
					load_reg <= 1'b1;
				end
			end
			if (rise[`K_UP] && single_ok) begin
				if (mode_toggle_key_mode)
					page_value <= page_value + 16'h0001;
				else begin
					page_num <= page_num + 8'h01;
					load_reg <= 1'b1;
				end
			end
			if (rise[`K_SAVE] && single_ok && mode_toggle_key_mode) begin
				value_save_pulse <= 1'b1;
				save_addr_reg    <= page_num;
			end
			if (rise[`K_DIR] && single_ok && keypad_sel)
				ref_reverse <= ~ref_reverse;
			if (rise[`K_STOP] && single_ok &&
			    (keypad_sel || ctrl_sko_reg == `SETTING_ENABLED))
				run_cmd <= 1'b0;
			else if (rise[`K_START] && single_ok && keypad_sel)
				run_cmd <= 1'b1;
			if (ch_mon && !(key_prev_reg[`K_DOWN] & key_prev_reg[`K_UP])) begin
				load_reg <= 1'b1;
				case (mon_reg)
					`MON_OFF: begin
						mon_ret_reg <= page_num;
						page_num    <= `PAGE_ACCESS;
						mon_reg     <= `MON_ACCESS;
					end
					`MON_ACCESS: begin
						page_num <= `PAGE_MEASURE;
						mon_reg  <= `MON_MEASURE;
					end
					`MON_MEASURE: begin
						page_num <= `PAGE_STATUS;
						mon_reg  <= `MON_STATUS;
					end
					default: begin
						page_num <= mon_ret_reg;
						mon_reg  <= `MON_OFF;
					end
				endcase
			end
			// local switch, toggles back on repeat
			if (ch_local && !(key_prev_reg[`K_UP] & key_prev_reg[`K_SAVE]) &&
			    ctrl_lsp_reg == `SETTING_ENABLED && !drive_firing) begin
				local_mode <= ~local_mode;
				if (!local_mode) begin
					page_num  <= `PAGE_MEASURE;
					mode_toggle_key_mode <= 1'b1;
				end
			end
		end
	end

	// blink timebase shared by the flashing run, direction and local LEDs
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_reg <= 24'h000000;
			blink_reg     <= 1'b0;
		end else if (clk_en) begin
			if (blink_cnt_reg == BLINK_CYCLES[23:0] - 24'h000001) begin
				blink_cnt_reg <= 24'h000000;
				blink_reg     <= ~blink_reg;
			end else
				blink_cnt_reg <= blink_cnt_reg + 24'h000001;
		end
	end

	// status inputs share core_clk, so no sync stages
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_src_active          <= 4'h0;
			ref_src_active          <= 4'h0;
			run_led                 <= 1'b0;
			board_run_led           <= 1'b0;
			ref_led                 <= 1'b0;
			fwd_led                 <= 1'b0;
			rev_led                 <= 1'b0;
			local_command_led       <= 1'b0;
			local_reference_led     <= 1'b0;
			brake_led               <= 1'b0;
			current_limit_led       <= 1'b0;
			board_current_limit_led <= 1'b0;
		end else if (clk_en) begin
			cmd_src_active <= cmd_src;
			ref_src_active <= ref_src;
			run_led       <= drive_firing & (~stop_ramp_active | blink_reg);
			board_run_led <= drive_firing & (~stop_ramp_active | blink_reg);
			if (speed_ref_cfg)
				ref_led <= speed_ref_nonzero;
			else
				ref_led <= current_ref_cfg & current_ref_nonzero;
			if (drive_firing) begin
				fwd_led <= ~motor_reverse;
				rev_led <= motor_reverse;
			end else begin
				fwd_led <= ~prepared_ref_negative & blink_reg;
				rev_led <= prepared_ref_negative & blink_reg;
			end
			local_command_led <= keypad_sel &
				((cmd_src == (4'h1 << `SRC_KEYPAD_BIT)) | blink_reg);
			local_reference_led <= stepped_sel &
				((ref_src == (4'h1 << `SRC_STEPPED_BIT)) | blink_reg);
			brake_led               <= braking_active;
			current_limit_led       <= current_limit;
			board_current_limit_led <= current_limit;
		end
	end

	// AXI4-Lite slave: takes address and data together, one cycle later answers
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (s_axi_araddr)
			`REG_CTRL:      rd_mux = {30'h0, ctrl_sko_reg, ctrl_lsp_reg};
			`REG_SRC:       rd_mux = {24'h0, ref_src, cmd_src};
			`REG_STATUS:    rd_mux = {23'h0, PAGE_CHARS[5:0] == `DISPLAY_CHARS,
				alarm_reset, local_mode, run_cmd, ref_reverse, jog_cmd,
				mon_reg, mode_toggle_key_mode};
			`REG_PAGE:      rd_mux = {24'h0, page_num};
			`REG_VALUE:     rd_mux = {16'h0, page_value};
			`REG_KEYS:      rd_mux = {24'h0, key_lvl};
			`REG_SAVED_SRC: rd_mux = {24'h0, saved_ref_reg, saved_cmd_reg};
			`REG_SAVE_ADDR: rd_mux = {24'h0, save_addr_reg};
			default:        rd_mux = 32'h00000000;
		endcase
	end
	wire rd_ok = s_axi_araddr <= `REG_SAVE_ADDR && s_axi_araddr[1:0] == 2'h0;
	wire wr_ok = s_axi_awaddr <= `REG_SAVE_ADDR && s_axi_awaddr[1:0] == 2'h0;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			ctrl_lsp_reg  <= 1'b0;
			ctrl_sko_reg  <= 1'b0;
			saved_cmd_reg <= 4'h0;
			saved_ref_reg <= 4'h0;
		end else if (clk_en) begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			s_axi_arready <= rd_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
				if (s_axi_awaddr == `REG_CTRL && s_axi_wstrb[0]) begin
					ctrl_lsp_reg <= s_axi_wdata[`CTRL_LSP_BIT];
					ctrl_sko_reg <= s_axi_wdata[`CTRL_SKO_BIT];
				end
				// saved source selection used at power-up
				if (s_axi_awaddr == `REG_SAVED_SRC && s_axi_wstrb[0]) begin
					saved_cmd_reg <= s_axi_wdata[`SRC_CMD_LSB +: `SRC_CMD_W];
					saved_ref_reg <= s_axi_wdata[`SRC_REF_LSB +: `SRC_REF_W];
				end
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // keypad_key_led_controller
`default_nettype wire

/* logic/keypad_map.vh */
`ifndef KEYPAD_MAP_VH
`define KEYPAD_MAP_VH
// register byte offsets
`define REG_CTRL        8'h00
`define REG_SRC         8'h04
`define REG_STATUS      8'h08
`define REG_PAGE        8'h0C
`define REG_VALUE       8'h10
`define REG_KEYS        8'h14
`define REG_SAVED_SRC   8'h18
`define REG_SAVE_ADDR   8'h1C
// ctrl fields
`define CTRL_LSP_BIT    0
`define CTRL_SKO_BIT    1
// source fields
`define SRC_CMD_LSB     0
`define SRC_CMD_W       4
`define SRC_REF_LSB     4
`define SRC_REF_W       4
`define SRC_KEYPAD_BIT  1
`define SRC_STEPPED_BIT 1
// key indices
`define K_MODE          0
`define K_DOWN          1
`define K_UP            2
`define K_SAVE          3
`define K_JOG           4
`define K_DIR           5
`define K_START         6
`define K_STOP          7
// setting values
`define SETTING_ENABLED 1'b0
// pages
`define PAGE_ACCESS     8'h00
`define PAGE_MEASURE    8'hFE
`define PAGE_STATUS     8'hFF
// chord cycle states
`define MON_OFF         2'h0
`define MON_ACCESS      2'h1
`define MON_MEASURE     2'h2
`define MON_STATUS      2'h3
// timing, display size and bus responses
`define DEBOUNCE_MS     10
`define CLK_KHZ         25000
`define BLINK_MS        250
`define DISPLAY_CHARS   32
`define DISPLAY_COLS    16
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* logic/page_store.v */
`timescale 1ns/1ps
`default_nettype none
`include "keypad_map.vh"
// non-volatile work area model: 256 page values
module page_store (
	input  wire        core_clk,
	input  wire        clk_en,
	input  wire        wr_en,
	input  wire [7:0]  wr_addr,
	input  wire [15:0] wr_data,
	input  wire [7:0]  rd_addr,
	output reg  [15:0] rd_data
);
	reg [15:0] mem [0:255];
	always @(posedge core_clk) begin
		if (clk_en) begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			rd_data <= mem[rd_addr];
		end
	end
endmodule // page_store
`default_nettype wire

/* verification/keypad_key_led_controller_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module keypad_checker (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       drive_firing,
	input wire logic       stop_ramp_active,
	input wire logic       speed_ref_cfg,
	input wire logic       speed_ref_nonzero,
	input wire logic       current_ref_nonzero,
	input wire logic       motor_reverse,
	input wire logic       braking_active,
	input wire logic       current_limit,
	input wire logic       mode_toggle_key_mode,
	input wire logic       value_save_pulse,
	input wire logic       jog_cmd,
	input wire logic       run_cmd,
	input wire logic       alarm_reset,
	input wire logic       local_mode,
	input wire logic [3:0] cmd_src_active,
	input wire logic [3:0] ref_src_active,
	input wire logic       run_led,
	input wire logic       board_run_led,
	input wire logic       ref_led,
	input wire logic       fwd_led,
	input wire logic       rev_led,
	input wire logic       brake_led,
	input wire logic       current_limit_led,
	input wire logic       board_current_limit_led
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	run_lit_a: assert property (
		(drive_firing && !stop_ramp_active)[*3] |-> run_led && board_run_led)
		else $error("run led dark while firing");
	brake_lit_a: assert property (
		braking_active[*3] |-> brake_led) else $error("brake led dark");
	limit_mirror_a: assert property (
		current_limit[*3] |-> current_limit_led && board_current_limit_led)
		else $error("current limit leds dark");
	ref_speed_a: assert property (
		(speed_ref_cfg && speed_ref_nonzero)[*3] |-> ref_led) else $error("ref led dark");
	ref_dark_a: assert property (
		(!speed_ref_nonzero && !current_ref_nonzero)[*3] |-> !ref_led)
		else $error("ref led lit with zero references");
	fwd_dir_a: assert property (
		(drive_firing && !motor_reverse)[*3] |-> fwd_led && !rev_led)
		else $error("direction leds wrong");
	save_pulse_a: assert property (
		value_save_pulse |-> mode_toggle_key_mode ##1 !value_save_pulse)
		else $error("save pulse outside programming");
	local_src_a: assert property (
		local_mode[*3] |-> cmd_src_active == 4'h2 && ref_src_active == 4'h2)
		else $error("local mode sources wrong");
	local_idle_a: assert property (
		$rose(local_mode) |-> !$past(drive_firing)) else $error("local entered while running");
	run_src_a: assert property (
		$rose(run_cmd) |-> cmd_src_active[1]) else $error("run without keypad source");
	jog_src_a: assert property (
		$rose(jog_cmd) |-> cmd_src_active[1]) else $error("jog without keypad source");
	cover property ($rose(local_mode));
	cover property ($rose(alarm_reset));
	cover property ($rose(jog_cmd));
endmodule // keypad_checker
bind keypad_key_led_controller keypad_checker chk_i (.core_clk, .rst_n, .drive_firing,
	.stop_ramp_active, .speed_ref_cfg, .speed_ref_nonzero, .current_ref_nonzero, .motor_reverse,
	.braking_active, .current_limit, .mode_toggle_key_mode, .value_save_pulse, .jog_cmd, .run_cmd,
	.alarm_reset, .local_mode, .cmd_src_active, .ref_src_active, .run_led, .board_run_led,
	.ref_led, .fwd_led, .rev_led, .brake_led, .current_limit_led, .board_current_limit_led);
`default_nettype wire

/* verification/keypad_operator.sv */
`timescale 1ns/1ps
`default_nettype none
// operator at the keypad: contacts chatter for a few cycles on every change
module keypad_operator (
	input  wire logic       core_clk,
	input  wire logic [7:0] press,
	output var  logic [7:0] key_pins
);
	logic [7:0] last = 8'h00;
	logic [7:0] chg  = 8'h00;
	logic [1:0] cnt  = 2'h0;
	// real contacts never settle at once, so debounce is exercised
	always @(posedge core_clk) begin
		last <= press;
		if (press != last) begin
			chg <= press ^ last;
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
		key_pins <= (cnt != 2'h0) ? (key_pins ^ chg) : press;
	end
endmodule // keypad_operator
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, awaddr_valid_dummy = 1'h0;
	logic [7:0]  press = 8'h00, key_pins, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        drive_firing = 1'h0, stop_ramp_active = 1'h0, speed_ref_cfg = 1'h0;
	logic        current_ref_cfg = 1'h0, speed_ref_nonzero = 1'h0, current_ref_nonzero = 1'h0;
	logic        motor_reverse = 1'h0, prepared_ref_negative = 1'h0, braking_active = 1'h0;
	logic        current_limit = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, s;
	logic [3:0]  s_axi_wstrb = 4'hF, cmd_src_active, ref_src_active;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        mode_toggle_key_mode, value_save_pulse, jog_cmd, ref_reverse, run_cmd, alarm_reset;
	logic        local_mode, run_led, board_run_led, ref_led, fwd_led, rev_led, brake_led;
	logic        local_command_led, local_reference_led, current_limit_led, board_current_limit_led;
	logic [7:0]  page_num;
	logic [15:0] page_value;
	logic        saw_save = 1'h0;
	int          failures = 0, n_tests = 0;

	keypad_key_led_controller #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4)) DUT (.core_clk, .rst_n,
		.clk_en, .key_pins, .drive_firing, .stop_ramp_active, .speed_ref_cfg, .current_ref_cfg,
		.speed_ref_nonzero, .current_ref_nonzero, .motor_reverse, .prepared_ref_negative,
		.braking_active, .current_limit, .awaddr_valid_dummy, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_toggle_key_mode, .page_num,
		.page_value, .value_save_pulse, .jog_cmd, .ref_reverse, .run_cmd, .alarm_reset,
		.local_mode, .cmd_src_active, .ref_src_active, .run_led, .board_run_led, .ref_led,
		.fwd_led, .rev_led, .local_command_led, .local_reference_led, .brake_led,
		.current_limit_led, .board_current_limit_led);
	keypad_operator op (.core_clk, .press, .key_pins);

	initial begin
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (value_save_pulse === 1'h1) saw_save <= 1'h1;
	end

	task finish_test;
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task key(input logic [7:0] m);
		press <= m;
		tick(16);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		s_axi_bready <= 1'h0;
		if (i == 40) begin
			failures++;
			finish_test;
		end
		chk(s_axi_bresp, er);
		tick(1);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		s_axi_rready <= 1'h0;
		if (i == 40) begin
			failures++;
			finish_test;
		end
		v = s_axi_rdata;
		chk(s_axi_rresp, er);
		tick(1);
	endtask

	task t_bus;
		chk({mode_toggle_key_mode, run_cmd, local_mode, page_num}, 32'h0);
		wr(`REG_SAVED_SRC, 32'h22, `RESP_OKAY);
		rd(`REG_SRC, `RESP_OKAY, d);
		chk(d[7:0], 32'h22);
		rd(`REG_STATUS, `RESP_OKAY, d);
		chk(d[8], 32'h1);
		rd(8'h20, `RESP_SLVERR, d);
		wr(8'h22, 32'h1, `RESP_SLVERR);
	endtask
	task t_mode_toggle_key;
		key(8'h04); key(8'h00); chk(page_num, 32'h1);
		key(8'h02); key(8'h00); chk(page_num, 32'h0);
		key(8'h01); key(8'h00); chk(mode_toggle_key_mode, 32'h1);
		wr(`REG_VALUE, 32'h5, `RESP_OKAY);
		key(8'h04); key(8'h00); chk(page_value, 32'h6);
		key(8'h02); key(8'h00); chk({page_num, page_value}, 32'h5);
		key(8'h08); key(8'h00); chk(saw_save, 32'h1);
		key(8'h01); key(8'h00); chk(mode_toggle_key_mode, 32'h0);
		saw_save <= 1'h0;
		key(8'h08); key(8'h00); chk(saw_save, 32'h0);
		key(8'h04); key(8'h00); key(8'h02); key(8'h00);
		chk(page_value, 32'h5);
	endtask
	task t_cmds;
		key(8'h40); key(8'h00); chk(run_cmd, 32'h1);
		key(8'h10); chk(jog_cmd, 32'h1);
		key(8'h00); chk(jog_cmd, 32'h0);
		key(8'h20); key(8'h00); chk(ref_reverse, 32'h1);
		wr(`REG_SAVED_SRC, 32'h11, `RESP_OKAY);
		key(8'h20); key(8'h00); chk(ref_reverse, 32'h1);
		wr(`REG_CTRL, 32'h2, `RESP_OKAY);
		key(8'h80); key(8'h00); chk(run_cmd, 32'h1);
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		key(8'h80); key(8'h00); chk(run_cmd, 32'h0);
		key(8'h40); key(8'h00); chk(run_cmd, 32'h0);
		key(8'h10); chk(jog_cmd, 32'h0);
		key(8'h00);
		wr(`REG_SAVED_SRC, 32'h22, `RESP_OKAY);
	endtask
	task t_chords;
		key(8'h09); chk({alarm_reset, mode_toggle_key_mode}, 32'h2);
		key(8'h00); chk(mode_toggle_key_mode, 32'h0);
		key(8'h04); key(8'h00);
		key(8'h06); key(8'h00); chk(page_num, 32'h00);
		key(8'h06); key(8'h00); chk(page_num, 32'hFE);
		key(8'h06); key(8'h00); chk(page_num, 32'hFF);
		key(8'h06); key(8'h00); chk(page_num, 32'h01);
	endtask
	task t_local;
		wr(`REG_SAVED_SRC, 32'h33, `RESP_OKAY);
		wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		key(8'h0C); key(8'h00); chk(local_mode, 32'h0);
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		drive_firing <= 1'h1;
		key(8'h0C); key(8'h00); chk(local_mode, 32'h0);
		drive_firing <= 1'h0;
		key(8'h0C); key(8'h00); chk(local_mode, 32'h1);
		chk({cmd_src_active, ref_src_active, page_num}, 32'h22FE);
		rst_n <= 1'h0;
		tick(2);
		rst_n <= 1'h1;
		tick(1);
		chk(local_mode, 32'h0);
		rd(`REG_SAVED_SRC, `RESP_OKAY, s);
		rd(`REG_SRC, `RESP_OKAY, d);
		chk(d[7:0], s[7:0]);
	endtask
	task t_leds;
		wr(`REG_SAVED_SRC, 32'h22, `RESP_OKAY);
		drive_firing <= 1'h1;
		braking_active <= 1'h1;
		current_limit <= 1'h1;
		speed_ref_cfg <= 1'h1;
		speed_ref_nonzero <= 1'h1;
		tick(6);
		chk({run_led, board_run_led, fwd_led, rev_led}, 32'hE);
		chk({brake_led, current_limit_led, board_current_limit_led}, 32'h7);
		chk({ref_led, local_command_led, local_reference_led}, 32'h7);
		speed_ref_cfg <= 1'h0;
		speed_ref_nonzero <= 1'h0;
		current_ref_cfg <= 1'h1;
		current_ref_nonzero <= 1'h1;
		tick(6);
		chk(ref_led, 32'h1);
		current_ref_nonzero <= 1'h0;
		tick(6);
		chk(ref_led, 32'h0);
		stop_ramp_active <= 1'h1;
		tick(3);
		d[0] = run_led;
		tick(4);
		chk(d[0] ^ run_led, 32'h1);
		drive_firing <= 1'h0;
		wr(`REG_SAVED_SRC, 32'h33, `RESP_OKAY);
		tick(2);
		d[2:0] = {fwd_led, local_command_led, local_reference_led};
		tick(4);
		chk(d[2:0] ^ {fwd_led, local_command_led, local_reference_led}, 32'h7);
		chk(rev_led, 32'h0);
	endtask

	initial begin
		tick(6);
		rst_n <= 1'h1;
		tick(1);
		t_bus;
		t_mode_toggle_key;
		t_cmds;
		t_chords;
		t_local;
		t_leds;
		finish_test;
	end
endmodule // tb
`default_nettype wire
